// File: scw_host_end.sv
// Host end: turns one address/data request into a framed eight-bit serial write.
// Assumes a user on sys_clk that holds req_valid until req_ready.
module scw_host_end
   import scw_pkg::*;
#(
   parameter int FRAME_LOW_CYC = SCW_FRAME_LOW_CYC,
   parameter int FRAME_SETUP_CYC = SCW_FRAME_SETUP_CYC,
   parameter int FRAME_HOLD_CYC = SCW_FRAME_HOLD_CYC,
   parameter int CLK_HALF_CYC = SCW_CLK_HALF_CYC
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   scw_if.host link,
   input wire logic req_valid,
   input wire logic [SCW_ADDR_W-1:0] req_addr,
   input wire logic [SCW_DATA_W-1:0] req_data,
   output logic req_ready,
   output logic done
);
   if (FRAME_LOW_CYC < 1 || FRAME_LOW_CYC > 256 || FRAME_SETUP_CYC < 1 || FRAME_SETUP_CYC > 256
       || FRAME_HOLD_CYC < 1 || FRAME_HOLD_CYC > 256 || CLK_HALF_CYC < 1 || CLK_HALF_CYC > 256)
   begin : g_bad_timing
      $error("scw_host_end: timing counts must lie in 1..256");
   end

   scw_host_state_t state_reg, state_next;
   logic [7:0] timer_reg, timer_next;
   logic [2:0] bit_reg, bit_next;
   logic [SCW_WORD_W-1:0] word_reg, word_next;
   logic frame_reg, frame_next;
   logic clk_reg, clk_next;
   logic sdo_reg, sdo_next;
   logic done_reg, done_next;

   assign req_ready = (state_reg == SCW_HOST_IDLE);
   assign done = done_reg;
   assign link.write_frame_pin = frame_reg;
   assign link.ser_clk = clk_reg;
   assign link.serial_write_in = sdo_reg;

   always_comb
   begin
      state_next = state_reg;
      timer_next = timer_reg;
      bit_next = bit_reg;
      word_next = word_reg;
      frame_next = frame_reg;
      clk_next = clk_reg;
      sdo_next = sdo_reg;
      done_next = 1'b0;
      if (state_reg != SCW_HOST_IDLE && timer_reg != 8'h00)
      begin
         timer_next = timer_reg - 8'h01;
      end
      unique case (state_reg)
         SCW_HOST_IDLE:
         begin
            if (req_valid)
            begin
               // Address goes first, both fields LSB first
               word_next = {req_data, req_addr};
               frame_next = 1'b0;
               timer_next = 8'(FRAME_LOW_CYC - 1);
               state_next = SCW_HOST_FRAME_LOW;
            end
         end
         SCW_HOST_FRAME_LOW:
         begin
            if (timer_reg == 8'h00)
            begin
               frame_next = 1'b1;
               timer_next = 8'(FRAME_SETUP_CYC - 1);
               state_next = SCW_HOST_SETUP;
            end
         end
         SCW_HOST_SETUP:
         begin
            if (timer_reg == 8'h00)
            begin
               clk_next = 1'b0;
               sdo_next = word_reg[0];
               bit_next = 3'h0;
               timer_next = 8'(CLK_HALF_CYC - 1);
               state_next = SCW_HOST_CLK_LOW;
            end
         end
         SCW_HOST_CLK_LOW:
         begin
            if (timer_reg == 8'h00)
            begin
               clk_next = 1'b1;
               timer_next = 8'(CLK_HALF_CYC - 1);
               state_next = SCW_HOST_CLK_HIGH;
            end
         end
         SCW_HOST_CLK_HIGH:
         begin
            if (timer_reg == 8'h00)
            begin
               if (bit_reg == SCW_LAST_BIT)
               begin
                  timer_next = 8'(FRAME_HOLD_CYC - 1);
                  state_next = SCW_HOST_HOLD;
               end
               else
               begin
                  // Data changes in the same cycle as the clock falls, half a clock period clear of the rising edge
                  clk_next = 1'b0;
                  word_next = {1'b0, word_reg[SCW_WORD_W-1:1]};
                  sdo_next = word_reg[1];
                  bit_next = bit_reg + 3'h1;
                  timer_next = 8'(CLK_HALF_CYC - 1);
                  state_next = SCW_HOST_CLK_LOW;
               end
            end
         end
         SCW_HOST_HOLD:
         begin
            if (timer_reg == 8'h00)
            begin
               done_next = 1'b1;
               state_next = SCW_HOST_IDLE;
            end
         end
         default:
         begin
            state_next = SCW_HOST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         state_reg <= SCW_HOST_IDLE;
         timer_reg <= 8'h00;
         bit_reg <= 3'h0;
         word_reg <= 8'h00;
         frame_reg <= 1'b1;
         clk_reg <= 1'b1;
         sdo_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         timer_reg <= timer_next;
         bit_reg <= bit_next;
         word_reg <= word_next;
         frame_reg <= frame_next;
         clk_reg <= clk_next;
         sdo_reg <= sdo_next;
         done_reg <= done_next;
      end
   end
endmodule : scw_host_end

// File: scw_pkg.sv
// Shared constants and state types for the serial control-register write port.
// Assumes both ends run on sys_clk at 125 MHz.
package scw_pkg;
   localparam int SCW_SYS_CLK_NS = 8;
   localparam int SCW_ADDR_W = 4;
   localparam int SCW_DATA_W = 4;
   localparam int SCW_WORD_W = SCW_ADDR_W + SCW_DATA_W;
   localparam int SCW_REG_COUNT = 16;
   localparam logic [3:0] SCW_REG_RESET = 4'h0;
   localparam logic [3:0] SCW_MODE_ADDR = 4'h0;
   localparam int SCW_SYNC_READ_BIT = 0;
   localparam int SCW_ALT_TONE_BIT = 2;
   localparam logic [2:0] SCW_LAST_BIT = 3'h7;
   // Link timing, least times, so rounded up
   localparam int SCW_T_FRAME_LOW_NS = 1000;
   localparam int SCW_T_FRAME_SETUP_NS = 1000;
   localparam int SCW_T_FRAME_HOLD_NS = 1000;
   localparam int SCW_T_CLK_HALF_NS = 500;
   localparam int SCW_FRAME_LOW_CYC = (SCW_T_FRAME_LOW_NS + SCW_SYS_CLK_NS - 1) / SCW_SYS_CLK_NS;
   localparam int SCW_FRAME_SETUP_CYC =
      (SCW_T_FRAME_SETUP_NS + SCW_SYS_CLK_NS - 1) / SCW_SYS_CLK_NS;
   localparam int SCW_FRAME_HOLD_CYC = (SCW_T_FRAME_HOLD_NS + SCW_SYS_CLK_NS - 1) / SCW_SYS_CLK_NS;
   localparam int SCW_CLK_HALF_CYC = (SCW_T_CLK_HALF_NS + SCW_SYS_CLK_NS - 1) / SCW_SYS_CLK_NS;
   typedef enum logic [0:0] {
      SCW_DEV_WAIT = 1'b0,
      SCW_DEV_SHIFT = 1'b1
   } scw_dev_state_t;
   typedef enum logic [2:0] {
      SCW_HOST_IDLE = 3'b000,
      SCW_HOST_FRAME_LOW = 3'b001,
      SCW_HOST_SETUP = 3'b010,
      SCW_HOST_CLK_LOW = 3'b011,
      SCW_HOST_CLK_HIGH = 3'b100,
      SCW_HOST_HOLD = 3'b101
   } scw_host_state_t;
endpackage : scw_pkg

// File: scw_if.sv
// Three-wire write link between the host end and the receiver end.
// Assumes the host drives every wire; the receiver only listens.
interface scw_if;
   logic write_frame_pin;
   logic ser_clk;
   logic serial_write_in;
   modport host (
      output write_frame_pin,
      output ser_clk,
      output serial_write_in
   );
   modport dev (
      input write_frame_pin,
      input ser_clk,
      input serial_write_in
   );
endinterface : scw_if

// File: scw_dev_end.sv
// Receiver end: control-register file loaded through the three-wire serial write link.
// Assumes the link pins are asynchronous to sys_clk and change far slower than it.
//
// What this block does
// - Host configures receiver by serial 8-bit writes.
// - Frame pin low resets write logic, counter.
// - Host holds frame pin high while shifting.
// - Sample data on first eight serial clock rising edges after frame pin high.
// - First four bits are register address.
// - Next four bits are register data.
// - Both fields shifted and assembled LSB first.
// - Address 0 bit 2 selects alternate tone mode.
// - Mode bit 0 selects clocked readout.
module scw_dev_end
   import scw_pkg::*;
#(
   parameter int REG_COUNT = SCW_REG_COUNT
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   scw_if.dev link,
   output logic [SCW_DATA_W*REG_COUNT-1:0] reg_file_flat,
   output logic alt_tone_mode,
   output logic sync_readout,
   output logic wr_strobe,
   output logic [SCW_ADDR_W-1:0] wr_addr,
   output logic [SCW_DATA_W-1:0] wr_data,
   output logic frame_abort,
   output logic frame_open
);
   if (REG_COUNT < 1 || REG_COUNT > SCW_REG_COUNT)
   begin : g_bad_count
      $error("scw_dev_end: REG_COUNT must lie in 1..16");
   end

   // Pin synchronisers; stage one feeds stage two only
   logic frame_s1_reg, frame_s2_reg;
   logic clk_s1_reg, clk_s2_reg, clk_prev_reg;
   logic data_s1_reg, data_s2_reg;
   logic clk_rise;

   scw_dev_state_t state_reg, state_next;
   logic [2:0] cnt_reg, cnt_next;
   logic [SCW_WORD_W-1:0] sh_reg, sh_next;
   logic [SCW_WORD_W-1:0] full_word;
   logic [SCW_DATA_W-1:0] regs_reg [REG_COUNT];
   logic [SCW_DATA_W-1:0] regs_next [REG_COUNT];
   logic wr_reg, wr_next;
   logic [SCW_ADDR_W-1:0] wa_reg, wa_next;
   logic [SCW_DATA_W-1:0] wd_reg, wd_next;
   logic abort_reg, abort_next;

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         frame_s1_reg <= 1'b1;
         frame_s2_reg <= 1'b1;
         clk_s1_reg <= 1'b1;
         clk_s2_reg <= 1'b1;
         clk_prev_reg <= 1'b1;
         data_s1_reg <= 1'b0;
         data_s2_reg <= 1'b0;
      end
      else
      begin
         frame_s1_reg <= link.write_frame_pin;
         frame_s2_reg <= frame_s1_reg;
         clk_s1_reg <= link.ser_clk;
         clk_s2_reg <= clk_s1_reg;
         clk_prev_reg <= clk_s2_reg;
         data_s1_reg <= link.serial_write_in;
         data_s2_reg <= data_s1_reg;
      end
   end

   // All three pins pass the same two stages, so data keeps its setup to the edge
   assign clk_rise = clk_s2_reg & ~clk_prev_reg;

   // Word as it stands once the current bit has been taken in at the top
   assign full_word = {data_s2_reg, sh_reg[SCW_WORD_W-1:1]};

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      wr_next = 1'b0;
      wa_next = wa_reg;
      wd_next = wd_reg;
      abort_next = 1'b0;
      for (int i = 0; i < REG_COUNT; i++)
      begin
         regs_next[i] = regs_reg[i];
      end
      if (!frame_s2_reg)
      begin
         // A frame cut short before the eighth bit is dropped, never half written
         if (state_reg == SCW_DEV_SHIFT && cnt_reg != 3'h0)
         begin
            abort_next = 1'b1;
         end
         state_next = SCW_DEV_SHIFT;
         cnt_next = 3'h0;
         sh_next = '0;
      end
      else if (state_reg == SCW_DEV_SHIFT && clk_rise)
      begin
         sh_next = full_word;
         if (cnt_reg == SCW_LAST_BIT)
         begin
            wr_next = 1'b1;
            wa_next = full_word[SCW_ADDR_W-1:0];
            wd_next = full_word[SCW_WORD_W-1:SCW_ADDR_W];
            // Addresses beyond the implemented registers are accepted and dropped
            if (int'(full_word[SCW_ADDR_W-1:0]) < REG_COUNT)
            begin
               regs_next[full_word[SCW_ADDR_W-1:0]] = full_word[SCW_WORD_W-1:SCW_ADDR_W];
            end
            state_next = SCW_DEV_WAIT;
            cnt_next = 3'h0;
         end
         else
         begin
            cnt_next = cnt_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!resetn)
      begin
         // Nothing is taken before the first frame pulse after reset
         state_reg <= SCW_DEV_WAIT;
         cnt_reg <= 3'h0;
         sh_reg <= '0;
         wr_reg <= 1'b0;
         wa_reg <= '0;
         wd_reg <= '0;
         abort_reg <= 1'b0;
         for (int i = 0; i < REG_COUNT; i++)
         begin
            regs_reg[i] <= SCW_REG_RESET;
         end
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         wr_reg <= wr_next;
         wa_reg <= wa_next;
         wd_reg <= wd_next;
         abort_reg <= abort_next;
         for (int i = 0; i < REG_COUNT; i++)
         begin
            regs_reg[i] <= regs_next[i];
         end
      end
   end

   for (genvar g = 0; g < REG_COUNT; g++)
   begin : g_flat
      assign reg_file_flat[g*SCW_DATA_W +: SCW_DATA_W] = regs_reg[g];
   end

   // Mode register fields steer the tone filters and the readout path
   assign alt_tone_mode = regs_reg[SCW_MODE_ADDR][SCW_ALT_TONE_BIT];
   assign sync_readout = regs_reg[SCW_MODE_ADDR][SCW_SYNC_READ_BIT];
   assign wr_strobe = wr_reg;
   assign wr_addr = wa_reg;
   assign wr_data = wd_reg;
   assign frame_abort = abort_reg;
   assign frame_open = (state_reg == SCW_DEV_SHIFT);
endmodule : scw_dev_end

// File: scw_link_monitor.sv
// Wire checker for the three-wire write link between host end and receiver end.
// Assumes the host timing parameters match those given to the host end.
module scw_link_monitor
   import scw_pkg::*;
#(
   parameter int FRAME_LOW_CYC = SCW_FRAME_LOW_CYC,
   parameter int FRAME_SETUP_CYC = SCW_FRAME_SETUP_CYC,
   parameter int CLK_HALF_CYC = SCW_CLK_HALF_CYC
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic write_frame_pin,
   input wire logic ser_clk,
   input wire logic serial_write_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_d_reg;
   logic [3:0] rise_cnt_reg;
   logic [3:0] rise_cnt_next;
   always_comb
   begin
      rise_cnt_next = rise_cnt_reg;
      if (!write_frame_pin)
      begin
         rise_cnt_next = 4'h0;
      end
      else if (ser_clk && !clk_d_reg && rise_cnt_reg < 4'h8)
      begin
         rise_cnt_next = rise_cnt_reg + 4'h1;
      end
   end
   always_ff @(posedge sys_clk)
   begin
      clk_d_reg <= resetn ? ser_clk : 1'b1;
      rise_cnt_reg <= resetn ? rise_cnt_next : 4'h0;
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   a_frame_low_width: assert property ($fell(write_frame_pin) |-> ##FRAME_LOW_CYC $rose(write_frame_pin))
      else $error("frame low pulse width wrong");
   a_clk_idle_low: assert property (!write_frame_pin |-> ser_clk)
      else $error("serial clock moved while frame low");
   a_setup_time: assert property ($rose(write_frame_pin) |-> ##FRAME_SETUP_CYC $fell(ser_clk))
      else $error("first clock phase not after frame setup");
   a_frame_held: assert property ($rose(ser_clk) && rise_cnt_reg == 4'h7 |-> write_frame_pin[*8])
      else $error("frame dropped around last bit");
   a_clk_half_low: assert property ($fell(ser_clk) |-> ##CLK_HALF_CYC $rose(ser_clk))
      else $error("clock low phase length wrong");
   a_data_steady: assert property ($rose(ser_clk) |-> $stable(serial_write_in))
      else $error("data changed at clock rise");
   a_eight_per_frame: assert property ($rose(ser_clk) |-> write_frame_pin && rise_cnt_reg < 4'h8)
      else $error("more than eight bits in a frame");
   a_full_frames: assert property ($fell(write_frame_pin) |-> rise_cnt_reg == 4'h0 || rise_cnt_reg == 4'h8)
      else $error("frame ended with partial word");
   c_frame: cover property ($fell(write_frame_pin));
   c_last_bit: cover property ($rose(ser_clk) && rise_cnt_reg == 4'h7);
   c_setup: cover property ($rose(write_frame_pin));
endmodule : scw_link_monitor

// File: testbench.sv
// Bench: host end drives one receiver end; a pin driver breaks the link rules on a second one.
// Assumes host end and checker keep their default link timing, so the real counts are exercised.
module testbench
   import scw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(name, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got); \
         fail_count++; \
      end \
   end
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic req_valid = 1'b0;
   logic [3:0] req_addr = 4'h0;
   logic [3:0] req_data = 4'h0;
   logic req_ready, done, wr_strobe, frame_open, alt_tone_mode, sync_readout;
   logic wr1_strobe, abort1, open1, abort0;
   logic [63:0] reg_file_flat, reg1_flat;
   logic [3:0] wr_addr, wr_data;
   logic [7:0] wire_word;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int strb_cnt = 0, strb1_cnt = 0, abort1_cnt = 0, abort0_cnt = 0;
   scw_if link0 ();
   scw_if link1 ();
   scw_host_end scw_host_end_inst (.sys_clk(sys_clk), .resetn(resetn), .link(link0),
      .req_valid(req_valid),
      .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready), .done(done));
   scw_dev_end scw_dev_end_inst (.sys_clk(sys_clk), .resetn(resetn), .link(link0),
      .reg_file_flat(reg_file_flat), .alt_tone_mode(alt_tone_mode), .sync_readout(sync_readout),
      .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .frame_abort(abort0),
      .frame_open(frame_open));
   // Second receiver faces the bench directly, so rule-breaking traffic stays off link0
   scw_dev_end scw_dev_end_inst2 (.sys_clk(sys_clk), .resetn(resetn), .link(link1),
      .reg_file_flat(reg1_flat), .alt_tone_mode(), .sync_readout(), .wr_strobe(wr1_strobe),
      .wr_addr(), .wr_data(), .frame_abort(abort1), .frame_open(open1));
   scw_link_monitor scw_link_monitor_inst (.sys_clk(sys_clk), .resetn(resetn),
      .write_frame_pin(link0.write_frame_pin), .ser_clk(link0.ser_clk),
      .serial_write_in(link0.serial_write_in));
   initial
   begin
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge link0.ser_clk)
   begin
      wire_word = {link0.serial_write_in, wire_word[7:1]};
   end
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      strb_cnt <= strb_cnt + int'(wr_strobe === 1'b1);
      strb1_cnt <= strb1_cnt + int'(wr1_strobe === 1'b1);
      abort1_cnt <= abort1_cnt + int'(abort1 === 1'b1);
      abort0_cnt <= abort0_cnt + int'(abort0 === 1'b1);
      // About 1400 cycles per host write at full timing, so this leaves ample margin
      if (cyc == 40000)
      begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic host_write(input logic [3:0] a, input logic [3:0] d);
      int s0;
      int n;
      s0 = strb_cnt;
      n = 0;
      @(negedge sys_clk);
      req_addr = a;
      req_data = d;
      req_valid = 1'b1;
      `CHK("ready idle", 1'b1, req_ready)
      @(negedge sys_clk);
      req_valid = 1'b0;
      `CHK("ready busy", 1'b0, req_ready)
      `CHK("frame low", 1'b0, link0.write_frame_pin)
      while (done !== 1'b1 && n < 2000)
      begin
         @(negedge sys_clk);
         n++;
      end
      `CHK("done", 1'b1, done)
      `CHK("ready back", 1'b1, req_ready)
      `CHK("strobes", s0 + 1, strb_cnt)
      `CHK("wire word", {d, a}, wire_word)
      `CHK("wr addr", a, wr_addr)
      `CHK("wr data", d, wr_data)
      `CHK("reg", d, reg_file_flat[int'(a)*4+:4])
   endtask : host_write
   task automatic pin_bit(input logic b);
      @(negedge sys_clk);
      link1.ser_clk = 1'b0;
      link1.serial_write_in = b;
      repeat (4) @(negedge sys_clk);
      link1.ser_clk = 1'b1;
      repeat (4) @(negedge sys_clk);
   endtask : pin_bit
   // Each frame also clocks once while the frame pin is low, which must be ignored
   task automatic pin_frame(input logic [7:0] w, input int nbits);
      link1.write_frame_pin = 1'b0;
      pin_bit(1'b1);
      link1.write_frame_pin = 1'b1;
      repeat (5) @(negedge sys_clk);
      for (int i = 0; i < nbits; i++)
      begin
         pin_bit(w[i%8]);
      end
   endtask : pin_frame
   task automatic t_all_regs();
      logic [63:0] exp_file;
      for (int a = 0; a < 16; a++)
      begin
         host_write(a[3:0], ~a[3:0]);
         exp_file[a*4+:4] = ~a[3:0];
      end
      `CHK("reg file", exp_file, reg_file_flat)
      `CHK("frame open", 1'b0, frame_open)
      `CHK("host aborts", 0, abort0_cnt)
      $display("test all_regs done");
   endtask : t_all_regs
   task automatic t_mode();
      logic [3:0] vals [4] = '{4'h4, 4'h1, 4'h5, 4'h0};
      foreach (vals[i])
      begin
         host_write(4'h0, vals[i]);
         `CHK("alt tone", vals[i][2], alt_tone_mode)
         `CHK("sync readout", vals[i][0], sync_readout)
      end
      $display("test mode done");
   endtask : t_mode
   task automatic t_faults();
      pin_bit(1'b1);
      pin_bit(1'b0);
      `CHK("early strobes", 0, strb1_cnt)
      pin_frame(8'h3a, 3);
      pin_frame(8'h96, 16);
      `CHK("aborts", 1, abort1_cnt)
      `CHK("strobes", 1, strb1_cnt)
      `CHK("reg", 64'h0000_0000_0900_0000, reg1_flat)
      `CHK("frame open", 1'b0, open1)
      $display("test faults done");
   endtask : t_faults
   // Reset in mid-run must clear written registers and leave both receivers waiting for a frame
   task automatic t_reset();
      @(negedge sys_clk);
      resetn = 1'b0;
      repeat (4) @(negedge sys_clk);
      resetn = 1'b1;
      @(negedge sys_clk);
      `CHK("regs after reset", 64'h0, reg_file_flat)
      `CHK("regs1 after reset", 64'h0, reg1_flat)
      `CHK("open after reset", 1'b0, frame_open)
      `CHK("open1 after reset", 1'b0, open1)
      `CHK("frame idle", 1'b1, link0.write_frame_pin)
      pin_bit(1'b1);
      `CHK("ignored rise", 1, strb1_cnt)
      host_write(4'h0, 4'h4);
      `CHK("alt tone again", 1'b1, alt_tone_mode)
      $display("test reset done");
   endtask : t_reset
   initial
   begin
      link1.write_frame_pin = 1'b1;
      link1.ser_clk = 1'b1;
      link1.serial_write_in = 1'b0;
      repeat (20) @(negedge sys_clk);
      resetn = 1'b1;
      @(negedge sys_clk);
      `CHK("reset regs", 64'h0, reg_file_flat)
      `CHK("reset mode", 2'h0, {alt_tone_mode, sync_readout})
      t_all_regs();
      t_mode();
      t_faults();
      t_reset();
      tally_and_finish();
   end
endmodule : testbench
